// [core/uart_device_end.sv]
// Behaviour
// - One full-duplex channel, serialise and deserialise concurrently
// - Ten distinct interrupt causes
// - CTS and RTS are active low
// - Host stops sending while device RTS high
// - Baud programmable from 1200 to 4M
// - Flow control is RTS/CTS or none
// - Parity none/odd/even, 8 data, 1/2 stop
// - Receive line low past timeout resets device
// - Device can drive break to wake host
// - Serial outputs tristate while device in reset
// - Other devices release lines after reset
// - Warm reset keeps baud, cold reset loses it
`timescale 1ns/100ps
module uart_device_end
	import uart_pkg::*;
#(
	parameter int BREAK_TIMEOUT = BREAK_TIMEOUT_CYC
) (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	uart_link_if.device            link,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [REG_W-1:0]  wdata,
	input  wire logic              wr,
	input  wire logic              rd,
	output logic [REG_W-1:0]       rdata,
	output logic                   irq,
	output logic                   device_reset
);
	typedef struct packed {
		logic                 rx_m;
		logic                 rx_s;
		logic                 cts_m;
		logic                 cts_s;
		logic                 cts_prev;
		line_state_type       rx_st;
		logic [BAUD_W-1:0]    rx_tmr;
		logic [BIT_W-1:0]     rx_bit;
		logic [DATA_W-1:0]    rx_shift;
		logic                 rx_perr;
		logic [DATA_W-1:0]    rx_hold;
		logic                 rx_full;
		line_state_type       tx_st;
		logic [BAUD_W-1:0]    tx_tmr;
		logic [BIT_W-1:0]     tx_bit;
		logic [DATA_W-1:0]    tx_shift;
		logic                 tx_stop_more;
		logic [DATA_W-1:0]    tx_hold;
		logic                 tx_full;
		logic                 tx_line;
		parity_type           par;
		logic                 stop2;
		logic                 flow_en;
		logic                 brk_send;
		logic [BAUD_W-1:0]    baud;
		logic [TIMEOUT_W-1:0] timeout;
		logic [TIMEOUT_W-1:0] brk_cnt;
		logic                 brk_armed;
		logic [IRQ_N-1:0]     irq_stat;
		logic [IRQ_N-1:0]     irq_mask;
		logic                 irq;
		logic [REG_W-1:0]     rdata;
		logic                 rts_n;
		logic                 oe_n;
		logic                 dev_reset;
	} dev_state_type;

	// Tristate and inactive RTS from the first reset edge
	localparam dev_state_type DEV_RST = '{rx_m: 1'b1, rx_s: 1'b1, cts_m: 1'b1, cts_s: 1'b1, cts_prev: 1'b1,
		rx_st: ST_IDLE, tx_st: ST_IDLE, tx_line: 1'b1, par: PAR_NONE, baud: DIV_DEFAULT,
		timeout: TIMEOUT_W'(BREAK_TIMEOUT), rts_n: 1'b1, oe_n: 1'b1, default: '0};

	dev_state_type     s_r;
	dev_state_type     s_nxt;
	logic [IRQ_N-1:0]  ev;
	logic [IRQ_N-1:0]  clr;
	dev_state_type     warm;

	always_comb begin
		s_nxt = s_r;
		ev = '0;
		clr = '0;
		warm = DEV_RST;
		s_nxt.rx_m = link.line_to_dev;
		s_nxt.rx_s = s_r.rx_m;
		s_nxt.cts_m = link.host_rts_line;
		s_nxt.cts_s = s_r.cts_m;
		s_nxt.cts_prev = s_r.cts_s;
		s_nxt.oe_n = 1'b0;
		s_nxt.dev_reset = 1'b0;
		s_nxt.rdata = '0;

		if (wr) begin
			case (addr)
				REG_CTRL: begin
					s_nxt.par = to_parity(wdata[CTRL_PAR_LSB +: 2]);
					s_nxt.stop2 = wdata[CTRL_STOP2];
					s_nxt.flow_en = wdata[CTRL_FLOW];
					s_nxt.brk_send = wdata[CTRL_BREAK];
				end
				REG_BAUD: s_nxt.baud = div_clamp(wdata[BAUD_W-1:0]);
				REG_TIMEOUT: s_nxt.timeout = wdata[TIMEOUT_W-1:0];
				REG_TXDATA: begin
					// A write while the holding word is full is dropped
					if (!s_r.tx_full) begin
						s_nxt.tx_hold = wdata[DATA_W-1:0];
						s_nxt.tx_full = 1'b1;
					end
				end
				REG_IRQ_MASK: s_nxt.irq_mask = wdata[IRQ_N-1:0];
				default: ;
			endcase
		end
		if (rd) begin
			case (addr)
				REG_CTRL: begin
					s_nxt.rdata[CTRL_PAR_LSB +: 2] = s_r.par;
					s_nxt.rdata[CTRL_STOP2] = s_r.stop2;
					s_nxt.rdata[CTRL_FLOW] = s_r.flow_en;
					s_nxt.rdata[CTRL_BREAK] = s_r.brk_send;
				end
				REG_BAUD: s_nxt.rdata[BAUD_W-1:0] = s_r.baud;
				REG_TIMEOUT: s_nxt.rdata[TIMEOUT_W-1:0] = s_r.timeout;
				REG_RXDATA: begin
					s_nxt.rdata[DATA_W-1:0] = s_r.rx_hold;
					s_nxt.rx_full = 1'b0;
				end
				REG_STATUS: begin
					s_nxt.rdata[STAT_RX_FULL] = s_r.rx_full;
					s_nxt.rdata[STAT_TX_FULL] = s_r.tx_full;
					s_nxt.rdata[STAT_TX_BUSY] = s_r.tx_st != ST_IDLE;
					s_nxt.rdata[STAT_CTS_N] = s_r.cts_s;
					s_nxt.rdata[STAT_RTS_N] = s_r.rts_n;
					s_nxt.rdata[STAT_RX_LINE] = s_r.rx_s;
				end
				REG_IRQ_STAT: begin
					s_nxt.rdata[IRQ_N-1:0] = s_r.irq_stat;
					clr = s_r.irq_stat;
				end
				REG_IRQ_MASK: s_nxt.rdata[IRQ_N-1:0] = s_r.irq_mask;
				default: ;
			endcase
		end

		s_nxt.rx_tmr = s_r.rx_tmr - BAUD_W'(1);
		case (s_r.rx_st)
			ST_IDLE: begin
				if (!s_r.rx_s) begin
					s_nxt.rx_st = ST_START;
					s_nxt.rx_tmr = s_r.baud >> 1;
				end
			end
			ST_START: begin
				// A low shorter than half a bit is a glitch, not a start bit
				if (s_r.rx_tmr == '0) begin
					s_nxt.rx_st = s_r.rx_s ? ST_IDLE : ST_DATA;
					s_nxt.rx_tmr = reload(s_r.baud);
					s_nxt.rx_bit = '0;
				end
			end
			ST_DATA: begin
				if (s_r.rx_tmr == '0) begin
					s_nxt.rx_shift = {s_r.rx_s, s_r.rx_shift[DATA_W-1:1]};
					s_nxt.rx_tmr = reload(s_r.baud);
					s_nxt.rx_bit = s_r.rx_bit + BIT_W'(1);
					s_nxt.rx_perr = 1'b0;
					if (s_r.rx_bit == LAST_BIT)
						s_nxt.rx_st = (s_r.par == PAR_NONE) ? ST_STOP : ST_PARITY;
				end
			end
			ST_PARITY: begin
				if (s_r.rx_tmr == '0) begin
					s_nxt.rx_perr = s_r.rx_s != parity_bit(s_r.rx_shift, s_r.par);
					s_nxt.rx_tmr = reload(s_r.baud);
					s_nxt.rx_st = ST_STOP;
				end
			end
			ST_STOP: begin
				if (s_r.rx_tmr == '0) begin
					s_nxt.rx_st = ST_IDLE;
					ev[IRQ_PARITY] = s_r.rx_perr;
					ev[IRQ_FRAMING] = ~s_r.rx_s;
					ev[IRQ_BREAK_RX] = ~s_r.rx_s & (s_r.rx_shift == '0);
					// Overrun if the host ignores RTS or flow control is off; the older word is kept
					if (s_nxt.rx_full)
						ev[IRQ_OVERRUN] = 1'b1;
					else begin
						s_nxt.rx_hold = s_r.rx_shift;
						s_nxt.rx_full = 1'b1;
						ev[IRQ_RX_READY] = 1'b1;
					end
				end
			end
			default: s_nxt.rx_st = ST_IDLE;
		endcase

		s_nxt.tx_tmr = s_r.tx_tmr - BAUD_W'(1);
		case (s_r.tx_st)
			ST_IDLE: begin
				s_nxt.tx_line = ~s_r.brk_send;
				ev[IRQ_BREAK_TX] = s_r.brk_send & s_r.tx_line;
				if (!s_r.brk_send && s_r.tx_full && (!s_r.flow_en || !s_r.cts_s)) begin
					s_nxt.tx_shift = s_r.tx_hold;
					s_nxt.tx_full = 1'b0;
					ev[IRQ_TX_EMPTY] = 1'b1;
					s_nxt.tx_st = ST_START;
					s_nxt.tx_tmr = reload(s_r.baud);
					s_nxt.tx_line = 1'b0;
				end
			end
			ST_START: begin
				if (s_r.tx_tmr == '0) begin
					s_nxt.tx_st = ST_DATA;
					s_nxt.tx_bit = '0;
					s_nxt.tx_line = s_r.tx_shift[0];
					s_nxt.tx_tmr = reload(s_r.baud);
				end
			end
			ST_DATA: begin
				if (s_r.tx_tmr == '0) begin
					s_nxt.tx_tmr = reload(s_r.baud);
					s_nxt.tx_bit = s_r.tx_bit + BIT_W'(1);
					s_nxt.tx_line = s_r.tx_shift[s_r.tx_bit + BIT_W'(1)];
					if (s_r.tx_bit == LAST_BIT) begin
						s_nxt.tx_st = (s_r.par == PAR_NONE) ? ST_STOP : ST_PARITY;
						s_nxt.tx_line = (s_r.par == PAR_NONE) ? 1'b1 : parity_bit(s_r.tx_shift, s_r.par);
						s_nxt.tx_stop_more = s_r.stop2;
					end
				end
			end
			ST_PARITY: begin
				if (s_r.tx_tmr == '0) begin
					s_nxt.tx_st = ST_STOP;
					s_nxt.tx_line = 1'b1;
					s_nxt.tx_tmr = reload(s_r.baud);
				end
			end
			ST_STOP: begin
				if (s_r.tx_tmr == '0) begin
					s_nxt.tx_tmr = reload(s_r.baud);
					s_nxt.tx_stop_more = 1'b0;
					if (!s_r.tx_stop_more) begin
						s_nxt.tx_st = ST_IDLE;
						ev[IRQ_TX_DONE] = 1'b1;
					end
				end
			end
			default: s_nxt.tx_st = ST_IDLE;
		endcase
		// Without flow control RTS stays asserted and overrun is the only guard
		s_nxt.rts_n = s_r.flow_en & s_nxt.rx_full;
		ev[IRQ_RTS_CHANGE] = s_nxt.rts_n != s_r.rts_n;
		ev[IRQ_CTS_CHANGE] = s_r.cts_s != s_r.cts_prev;
		s_nxt.irq_stat = (s_r.irq_stat & ~clr) | ev;
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
		// Counting arms only after a high, so a held break resets once
		if (s_r.rx_s) begin
			s_nxt.brk_cnt = '0;
			s_nxt.brk_armed = 1'b1;
		end else if (s_r.brk_armed) begin
			s_nxt.brk_cnt = s_r.brk_cnt + TIMEOUT_W'(1);
			if (s_r.brk_cnt >= s_r.timeout) begin
				warm.rx_m = s_nxt.rx_m;
				warm.rx_s = s_nxt.rx_s;
				warm.baud = s_r.baud;
				warm.timeout = s_r.timeout;
				warm.dev_reset = 1'b1;
				s_nxt = warm;
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			s_r <= DEV_RST;
		else
			s_r <= s_nxt;
	end

	assign link.dev_tx       = s_r.tx_line;
	assign link.dev_tx_oe_n  = s_r.oe_n;
	assign link.dev_rts_n    = s_r.rts_n;
	assign link.dev_rts_oe_n = s_r.oe_n;
	assign rdata        = s_r.rdata;
	assign irq          = s_r.irq;
	assign device_reset = s_r.dev_reset;
endmodule

// [common/uart_pkg.sv]
package uart_pkg;
	localparam int CLK_HZ   = 25_000_000;
	localparam int BAUD_STD = 115_200;
	localparam int BAUD_MIN = 1_200;
	localparam int BAUD_MAX = 4_000_000;
	localparam int BAUD_W   = 16;
	localparam int DATA_W   = 8;
	localparam int BIT_W    = 3;
	localparam int ADDR_W   = 4;
	localparam int REG_W    = 32;
	localparam int TIMEOUT_W = 24;
	localparam logic [BAUD_W-1:0] DIV_DEFAULT = BAUD_W'((CLK_HZ + BAUD_STD / 2) / BAUD_STD);
	localparam logic [BAUD_W-1:0] DIV_MIN     = BAUD_W'(CLK_HZ / BAUD_MAX);
	localparam logic [BAUD_W-1:0] DIV_MAX     = BAUD_W'(CLK_HZ / BAUD_MIN);
	localparam logic [BIT_W-1:0]  LAST_BIT    = BIT_W'(DATA_W - 1);
	// Default break_reset_timeout, in milliseconds and in mclk cycles
	localparam int BREAK_TIMEOUT_MS  = 100;
	localparam int BREAK_TIMEOUT_CYC = (CLK_HZ / 1000) * BREAK_TIMEOUT_MS;
	localparam logic [ADDR_W-1:0] REG_CTRL     = 4'h0;
	localparam logic [ADDR_W-1:0] REG_BAUD     = 4'h1;
	localparam logic [ADDR_W-1:0] REG_TIMEOUT  = 4'h2;
	localparam logic [ADDR_W-1:0] REG_TXDATA   = 4'h3;
	localparam logic [ADDR_W-1:0] REG_RXDATA   = 4'h4;
	localparam logic [ADDR_W-1:0] REG_STATUS   = 4'h5;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h6;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h7;
	localparam int CTRL_PAR_LSB = 0;
	localparam int CTRL_STOP2   = 2;
	localparam int CTRL_FLOW    = 3;
	localparam int CTRL_BREAK   = 4;
	localparam int STAT_RX_FULL = 0;
	localparam int STAT_TX_FULL = 1;
	localparam int STAT_TX_BUSY = 2;
	localparam int STAT_CTS_N   = 3;
	localparam int STAT_RTS_N   = 4;
	localparam int STAT_RX_LINE = 5;
	localparam int IRQ_N          = 10;
	localparam int IRQ_RX_READY   = 0;
	localparam int IRQ_TX_EMPTY   = 1;
	localparam int IRQ_TX_DONE    = 2;
	localparam int IRQ_PARITY     = 3;
	localparam int IRQ_FRAMING    = 4;
	localparam int IRQ_OVERRUN    = 5;
	localparam int IRQ_BREAK_RX   = 6;
	localparam int IRQ_CTS_CHANGE = 7;
	localparam int IRQ_RTS_CHANGE = 8;
	localparam int IRQ_BREAK_TX   = 9;

	typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_ODD = 2'h1, PAR_EVEN = 2'h2} parity_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0, ST_START = 3'h1, ST_DATA = 3'h3, ST_PARITY = 3'h2, ST_STOP = 3'h6
	} line_state_type;

	function automatic parity_type to_parity(input logic [1:0] code);
		to_parity = (code == 2'h1) ? PAR_ODD : (code == 2'h2) ? PAR_EVEN : PAR_NONE;
	endfunction

	function automatic logic parity_bit(input logic [DATA_W-1:0] d, input parity_type p);
		parity_bit = (p == PAR_ODD) ? ~^d : ^d;
	endfunction

	function automatic logic [BAUD_W-1:0] div_clamp(input logic [BAUD_W-1:0] d);
		div_clamp = (d < DIV_MIN) ? DIV_MIN : (d > DIV_MAX) ? DIV_MAX : d;
	endfunction

	function automatic logic [BAUD_W-1:0] reload(input logic [BAUD_W-1:0] d);
		reload = d - BAUD_W'(1);
	endfunction
endpackage

// [common/uart_link_if.sv]
`timescale 1ns/100ps
interface uart_link_if;
	logic dev_tx;
	logic dev_tx_oe_n;
	logic dev_rts_n;
	logic dev_rts_oe_n;
	logic host_tx;
	logic host_tx_oe_n;
	logic host_rts_n;
	logic host_rts_oe_n;
	// Pull-ups hold every undriven line high, as the idle line needs
	logic line_to_host;
	logic line_to_dev;
	logic dev_rts_line;
	logic host_rts_line;
	assign line_to_host  = dev_tx_oe_n ? 1'b1 : dev_tx;
	assign line_to_dev   = host_tx_oe_n ? 1'b1 : host_tx;
	assign dev_rts_line  = dev_rts_oe_n ? 1'b1 : dev_rts_n;
	assign host_rts_line = host_rts_oe_n ? 1'b1 : host_rts_n;
	modport device (output dev_tx, dev_tx_oe_n, dev_rts_n, dev_rts_oe_n, input line_to_dev, host_rts_line);
	modport host (output host_tx, host_tx_oe_n, host_rts_n, host_rts_oe_n, input line_to_host, dev_rts_line);
endinterface

// [core/uart_host_end.sv]
`timescale 1ns/100ps
module uart_host_end
	import uart_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              reset_n,
	uart_link_if.host              link,
	input  wire logic [BAUD_W-1:0] baud_div,
	input  wire logic [1:0]        parity_sel,
	input  wire logic              stop2,
	input  wire logic              flow_en,
	input  wire logic              send_break,
	input  wire logic              drive_en,
	input  wire logic [DATA_W-1:0] tx_data,
	input  wire logic              tx_valid,
	output logic                   tx_ready,
	output logic [DATA_W-1:0]      rx_data,
	output logic                   rx_valid,
	output logic                   rx_err
);
	typedef struct packed {
		logic                rx_m;
		logic                rx_s;
		logic                cts_m;
		logic                cts_s;
		line_state_type      rx_st;
		logic [BAUD_W-1:0]   rx_tmr;
		logic [BIT_W-1:0]    rx_bit;
		logic [DATA_W-1:0]   rx_shift;
		logic                rx_perr;
		logic [DATA_W-1:0]   rx_out;
		logic                rx_vld;
		logic                rx_bad;
		line_state_type      tx_st;
		logic [BAUD_W-1:0]   tx_tmr;
		logic [BIT_W-1:0]    tx_bit;
		logic [DATA_W-1:0]   tx_shift;
		logic                tx_stop_more;
		logic                tx_line;
		logic                tx_rdy;
		logic                oe_n;
	} host_state_type;

	localparam host_state_type HOST_RST = '{rx_m: 1'b1, rx_s: 1'b1, cts_m: 1'b1, cts_s: 1'b1,
		rx_st: ST_IDLE, tx_st: ST_IDLE, tx_line: 1'b1, oe_n: 1'b1, default: '0};

	host_state_type s_r;
	host_state_type s_nxt;
	logic [BAUD_W-1:0] div;
	parity_type        par;

	assign div = div_clamp(baud_div);
	assign par = to_parity(parity_sel);

	always_comb begin
		s_nxt = s_r;
		s_nxt.rx_m = link.line_to_host;
		s_nxt.rx_s = s_r.rx_m;
		s_nxt.cts_m = link.dev_rts_line;
		s_nxt.cts_s = s_r.cts_m;
		s_nxt.rx_vld = 1'b0;
		s_nxt.oe_n = ~drive_en;
		s_nxt.rx_tmr = s_r.rx_tmr - BAUD_W'(1);
		case (s_r.rx_st)
			ST_IDLE: begin
				if (!s_r.rx_s) begin
					s_nxt.rx_st = ST_START;
					s_nxt.rx_tmr = div >> 1;
				end
			end
			ST_START: begin
				if (s_r.rx_tmr == '0) begin
					s_nxt.rx_st = s_r.rx_s ? ST_IDLE : ST_DATA;
					s_nxt.rx_tmr = reload(div);
					s_nxt.rx_bit = '0;
				end
			end
			ST_DATA: begin
				if (s_r.rx_tmr == '0) begin
					s_nxt.rx_shift = {s_r.rx_s, s_r.rx_shift[DATA_W-1:1]};
					s_nxt.rx_tmr = reload(div);
					s_nxt.rx_bit = s_r.rx_bit + BIT_W'(1);
					s_nxt.rx_perr = 1'b0;
					if (s_r.rx_bit == LAST_BIT)
						s_nxt.rx_st = (par == PAR_NONE) ? ST_STOP : ST_PARITY;
				end
			end
			ST_PARITY: begin
				if (s_r.rx_tmr == '0) begin
					s_nxt.rx_perr = s_r.rx_s != parity_bit(s_r.rx_shift, par);
					s_nxt.rx_tmr = reload(div);
					s_nxt.rx_st = ST_STOP;
				end
			end
			ST_STOP: begin
				if (s_r.rx_tmr == '0) begin
					s_nxt.rx_st = ST_IDLE;
					s_nxt.rx_out = s_r.rx_shift;
					s_nxt.rx_vld = 1'b1;
					s_nxt.rx_bad = s_r.rx_perr | ~s_r.rx_s;
				end
			end
			default: s_nxt.rx_st = ST_IDLE;
		endcase

		s_nxt.tx_tmr = s_r.tx_tmr - BAUD_W'(1);
		s_nxt.tx_rdy = 1'b0;
		case (s_r.tx_st)
			ST_IDLE: begin
				s_nxt.tx_line = ~send_break;
				s_nxt.tx_rdy = ~send_break & (~flow_en | ~s_r.cts_s);
				if (s_r.tx_rdy && tx_valid) begin
					s_nxt.tx_rdy = 1'b0;
					s_nxt.tx_shift = tx_data;
					s_nxt.tx_st = ST_START;
					s_nxt.tx_tmr = reload(div);
					s_nxt.tx_line = 1'b0;
				end
			end
			ST_START: begin
				if (s_r.tx_tmr == '0) begin
					s_nxt.tx_st = ST_DATA;
					s_nxt.tx_bit = '0;
					s_nxt.tx_line = s_r.tx_shift[0];
					s_nxt.tx_tmr = reload(div);
				end
			end
			ST_DATA: begin
				if (s_r.tx_tmr == '0) begin
					s_nxt.tx_tmr = reload(div);
					s_nxt.tx_bit = s_r.tx_bit + BIT_W'(1);
					s_nxt.tx_line = s_r.tx_shift[s_r.tx_bit + BIT_W'(1)];
					if (s_r.tx_bit == LAST_BIT) begin
						s_nxt.tx_st = (par == PAR_NONE) ? ST_STOP : ST_PARITY;
						s_nxt.tx_line = (par == PAR_NONE) ? 1'b1 : parity_bit(s_r.tx_shift, par);
						s_nxt.tx_stop_more = stop2;
					end
				end
			end
			ST_PARITY: begin
				if (s_r.tx_tmr == '0) begin
					s_nxt.tx_st = ST_STOP;
					s_nxt.tx_line = 1'b1;
					s_nxt.tx_tmr = reload(div);
				end
			end
			ST_STOP: begin
				if (s_r.tx_tmr == '0) begin
					s_nxt.tx_tmr = reload(div);
					s_nxt.tx_stop_more = 1'b0;
					if (!s_r.tx_stop_more)
						s_nxt.tx_st = ST_IDLE;
				end
			end
			default: s_nxt.tx_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			s_r <= HOST_RST;
		else
			s_r <= s_nxt;
	end

	assign link.host_tx       = s_r.tx_line;
	assign link.host_tx_oe_n  = s_r.oe_n;
	assign link.host_rts_n    = 1'b0;
	assign link.host_rts_oe_n = s_r.oe_n;
	assign tx_ready = s_r.tx_rdy;
	assign rx_data  = s_r.rx_out;
	assign rx_valid = s_r.rx_vld;
	assign rx_err   = s_r.rx_bad;
endmodule

// [verification/uart_link_sva.sv]
`timescale 1ns/100ps
module uart_link_sva #(
	parameter int BIT_CYC = 16,
	parameter int TIMEOUT = 200
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic dev_tx,
	input wire logic dev_tx_oe_n,
	input wire logic dev_rts_n,
	input wire logic dev_rts_oe_n,
	input wire logic host_tx,
	input wire logic host_tx_oe_n,
	input wire logic host_rts_n,
	input wire logic host_rts_oe_n,
	input wire logic line_to_dev
);
	// Run lengths of low levels, counted in mclk cycles, and warm reset flags
	typedef struct packed {
		logic [31:0] dev_low;
		logic [31:0] host_low;
		logic [31:0] rx_low;
		logic        warm_seen;
		logic        oe_prev;
	} watch_type;

	watch_type watch_r;
	watch_type watch_nxt;

	always_comb begin
		watch_nxt = watch_r;
		watch_nxt.dev_low = (dev_tx || dev_tx_oe_n) ? 32'h0 : watch_r.dev_low + 32'h1;
		watch_nxt.host_low = (host_tx || host_tx_oe_n) ? 32'h0 : watch_r.host_low + 32'h1;
		watch_nxt.rx_low = line_to_dev ? 32'h0 : watch_r.rx_low + 32'h1;
		watch_nxt.oe_prev = dev_tx_oe_n;
		// Cleared only by a high line, since the device re-arms the same way
		if (line_to_dev) begin
			watch_nxt.warm_seen = 1'b0;
		end else if (dev_tx_oe_n && !watch_r.oe_prev) begin
			watch_nxt.warm_seen = 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			watch_r <= '{dev_low: 32'h0, host_low: 32'h0, rx_low: 32'h0, warm_seen: 1'b0, oe_prev: 1'b1};
		end else begin
			watch_r <= watch_nxt;
		end
	end

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	sequence released;
		$rose(reset_n);
	endsequence
	sequence warm_start;
		$rose(dev_tx_oe_n);
	endsequence
	sequence dev_low_end;
		$rose(dev_tx) && !dev_tx_oe_n;
	endsequence
	sequence host_low_end;
		$rose(host_tx) && !host_tx_oe_n;
	endsequence

	chk_reset_tristate: assert property (disable iff (1'b0) !reset_n |-> dev_tx_oe_n && dev_rts_oe_n)
		else $error("device lines driven during reset");
	chk_release_drive: assert property (disable iff (1'b0) released |=> !dev_tx_oe_n && !dev_rts_oe_n)
		else $error("device lines not driven after reset release");
	chk_rts_oe_pair: assert property (dev_rts_oe_n == dev_tx_oe_n)
		else $error("device enables disagree");
	chk_host_rts_ready: assert property (!host_rts_oe_n |-> !host_rts_n)
		else $error("host ready line not low");
	chk_dev_bit_width: assert property (dev_low_end |-> watch_r.dev_low >= BIT_CYC)
		else $error("device low run shorter than one bit");
	chk_host_bit_width: assert property (host_low_end |-> watch_r.host_low >= BIT_CYC)
		else $error("host low run shorter than one bit");
	chk_warm_one_cycle: assert property (warm_start |=> !dev_tx_oe_n)
		else $error("warm reset tristate longer than one cycle");
	chk_warm_needs_low: assert property (warm_start |-> watch_r.rx_low >= TIMEOUT)
		else $error("warm reset without a long break");
	chk_warm_deadline: assert property (watch_r.rx_low == TIMEOUT + 12 |-> watch_r.warm_seen)
		else $error("long break did not reset the device");
endmodule

// [verification/host_uart_with_break_reset_test.sv]
`timescale 1ns/100ps
module host_uart_with_break_reset_test
	import uart_pkg::*;
;
	localparam int BIT_CYC = 16;
	localparam int TIMEOUT = 200;
	logic              mclk       = 1'b0;
	logic              reset_n    = 1'b1;
	logic [ADDR_W-1:0] addr       = '0;
	logic [REG_W-1:0]  wdata      = '0;
	logic              wr         = 1'b0;
	logic              rd         = 1'b0;
	logic [REG_W-1:0]  rdata;
	logic              irq;
	logic              device_reset;
	logic [BAUD_W-1:0] baud_div   = BAUD_W'(BIT_CYC);
	logic [1:0]        parity_sel = 2'h0;
	logic              stop2      = 1'b0;
	logic              flow_en    = 1'b0;
	logic              send_break = 1'b0;
	logic              drive_en   = 1'b0;
	logic [DATA_W-1:0] tx_data    = 8'h00;
	logic              tx_valid   = 1'b0;
	logic              tx_ready;
	logic [DATA_W-1:0] rx_data;
	logic              rx_valid;
	logic              rx_err;
	logic [31:0]       d;
	int                fails = 0;
	int                comparisons = 0;
	int                n;
	logic [1:0]        dp [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
	logic [1:0]        hp [4] = '{2'h0, 2'h1, 2'h2, 2'h2};
	logic [7:0]        bt [4] = '{8'hA5, 8'h01, 8'hFE, 8'h37};

	uart_link_if link();
	uart_device_end #(.BREAK_TIMEOUT(TIMEOUT)) uart_device_end_i (.mclk, .reset_n, .link, .addr, .wdata, .wr, .rd,
		.rdata, .irq, .device_reset);
	uart_host_end uart_host_end_i (.mclk, .reset_n, .link, .baud_div, .parity_sel, .stop2, .flow_en, .send_break,
		.drive_en, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_err);
	uart_link_sva #(.BIT_CYC(BIT_CYC), .TIMEOUT(TIMEOUT)) uart_link_sva_i (.mclk(mclk), .reset_n(reset_n),
		.dev_tx(link.dev_tx), .dev_tx_oe_n(link.dev_tx_oe_n), .dev_rts_n(link.dev_rts_n),
		.dev_rts_oe_n(link.dev_rts_oe_n), .host_tx(link.host_tx), .host_tx_oe_n(link.host_tx_oe_n),
		.host_rts_n(link.host_rts_n), .host_rts_oe_n(link.host_rts_oe_n), .line_to_dev(link.line_to_dev));

	always #20 mclk = ~mclk;

	task automatic results;
		$display("comparisons=%0d fails=%0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [31:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask

	task automatic reg_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] v;
		reg_rd(a, v);
		check(v & mask, exp);
	endtask

	task automatic wait_rx_full;
		logic [31:0] s;
		s = '0;
		for (int k = 0; k < 400 && s[STAT_RX_FULL] !== 1'b1; k++) reg_rd(REG_STATUS, s);
	endtask

	task automatic host_send(input logic [7:0] b);
		int k;
		k = 0;
		@(posedge mclk);
		tx_data <= b;
		tx_valid <= 1'b1;
		do begin
			@(posedge mclk);
			k++;
		end while (tx_ready !== 1'b1 && k < 2000);
		tx_valid <= 1'b0;
		if (k >= 2000) begin
			fails++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		end
	endtask

	task automatic host_get(input logic [7:0] exp, input logic err);
		int k;
		k = 0;
		while (rx_valid !== 1'b1 && k < 2000) begin
			@(posedge mclk);
			#1 k++;
		end
		check({24'h0, rx_data}, {24'h0, exp});
		check(32'(rx_err), 32'(err));
	endtask

	initial begin
		#(40 * 60000);
		fails++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, 32'h0, 32'h1);
		results();
	end

	initial begin
		// A real falling edge so both ends and the checker leave the unknown state
		#1 reset_n = 1'b0;
		repeat (3) @(posedge mclk);
		check(32'(link.dev_tx_oe_n && link.dev_rts_oe_n), 32'h1);
		@(negedge mclk) reset_n = 1'b1;
		@(posedge mclk);
		#1 check({30'h0, link.dev_tx_oe_n, link.line_to_host}, 32'h1);
		check(32'(link.host_tx_oe_n), 32'h1);
		@(posedge mclk) drive_en <= 1'b1;
		reg_chk(REG_BAUD, 32'(DIV_DEFAULT), 32'hFFFF);
		reg_chk(REG_TIMEOUT, 32'(TIMEOUT), 32'hFFFFFF);
		reg_wr(REG_BAUD, 32'(BIT_CYC));
		reg_chk(REG_BAUD, 32'(BIT_CYC), 32'hFFFF);
		reg_rd(REG_IRQ_STAT, d);
		// Last entry pairs odd against even so the host must flag it
		for (int i = 0; i < 4; i++) begin
			@(posedge mclk);
			parity_sel <= hp[i];
			reg_wr(REG_CTRL, {29'h0, i[0], dp[i]});
			reg_wr(REG_IRQ_MASK, (i == 1) ? 32'h0 : 32'h3FF);
			reg_wr(REG_TXDATA, {24'h0, bt[i]});
			host_get(bt[i], i == 3);
			repeat (3 * BIT_CYC) @(posedge mclk);
			#1 check(32'(irq), (i == 1) ? 32'h0 : 32'h1);
			reg_chk(REG_IRQ_STAT, 32'h6, 32'h6);
			@(posedge mclk);
			#1 check(32'(irq), 32'h0);
		end
		@(posedge mclk) parity_sel <= 2'h0;
		reg_wr(REG_CTRL, 32'h0);
		reg_wr(REG_TXDATA, 32'h96);
		host_send(8'h3C);
		host_get(8'h96, 1'b0);
		wait_rx_full();
		host_send(8'hC3);
		repeat (12 * BIT_CYC) @(posedge mclk);
		reg_chk(REG_RXDATA, 32'h3C, 32'hFF);
		reg_chk(REG_IRQ_STAT, 32'h21, 32'h21);
		@(posedge mclk) flow_en <= 1'b1;
		reg_wr(REG_CTRL, 32'h8);
		host_send(8'h81);
		wait_rx_full();
		repeat (2) @(posedge mclk);
		check(32'(link.dev_rts_line), 32'h1);
		reg_chk(REG_STATUS, 32'h31, 32'h3F);
		@(posedge mclk);
		tx_data <= 8'h42;
		tx_valid <= 1'b1;
		repeat (4 * BIT_CYC) @(posedge mclk);
		check({30'h0, tx_ready, link.host_tx}, 32'h1);
		reg_chk(REG_RXDATA, 32'h81, 32'hFF);
		host_send(8'h42);
		wait_rx_full();
		reg_chk(REG_RXDATA, 32'h42, 32'hFF);
		reg_wr(REG_CTRL, 32'h18);
		repeat (3 * BIT_CYC) @(posedge mclk);
		check(32'(link.line_to_host), 32'h0);
		reg_chk(REG_IRQ_STAT, 32'h200, 32'h200);
		reg_wr(REG_CTRL, 32'h8);
		repeat (2) @(posedge mclk);
		check(32'(link.line_to_host), 32'h1);
		@(posedge mclk) send_break <= 1'b1;
		n = 0;
		while (device_reset !== 1'b1 && n < 4 * TIMEOUT) begin
			@(posedge mclk);
			#1 n++;
		end
		check(32'(n >= TIMEOUT && n < TIMEOUT + 12), 32'h1);
		// Hold the break past the deadline that the checker watches
		repeat (16) @(posedge mclk);
		send_break <= 1'b0;
		repeat (4) @(posedge mclk);
		reg_chk(REG_BAUD, 32'(BIT_CYC), 32'hFFFF);
		reg_chk(REG_TIMEOUT, 32'(TIMEOUT), 32'hFFFFFF);
		reg_chk(REG_CTRL, 32'h0, 32'h1F);
		results();
	end
endmodule
